// ===== hdl/kwiu_top.sv
// Purpose: Key wake input unit, edge or edge-and-level detection on key inputs
// Assumes: i_keys asynchronous to i_clk; APB master keeps psel/penable legal
// Notes:   Registers: control, pin enable, polarity, event status, event mask
// Operation
// RULE1: Falling edge is one sample high then next sample low.
// RULE2: With rising polarity, edge is one sample low then next high.
// RULE3: Sources hold enabled inputs deasserted before the first edge.
// RULE4: After an edge, no edge until every enabled input deasserts.
// RULE5: Edge mode: an edge on an enabled input sets the flag.
// RULE6: Level mode: edge or asserted level on enabled input sets flag.
// RULE7: Flag set and interrupt enable one raise the interrupt request.
// RULE8: Writing acknowledge one clears the flag; always in edge mode.
// RULE9: Level mode: acknowledge clears only if all enabled inputs deasserted.
// RULE10: Level mode: flag stays set if any enabled input asserted at acknowledge.
// RULE11: Software masks, sets polarity, pulls, enables, acknowledges, then unmasks.
// RULE12: Polarity zero means falling or low; one means rising or high.
// RULE13: Mode zero is edge only; mode one is edge and level.
// RULE14: Up to eight inputs, each with its own pin enable.
// RULE15: Flag is read only; writes to its bit do nothing.
// RULE16: Disabled inputs neither set the flag nor block its clearing.
// RULE17: Each input passes a two-stage synchroniser before comparison.
module kwiu_top
    import kwiu_pkg::*;
#(
    parameter int unsigned N_KEYS = KWIU_KEYS_DEF
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  wire logic [N_KEYS-1:0]      i_keys,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [KWIU_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]            i_pwdata,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output logic                        o_irq
);

    logic [N_KEYS-1:0]     sync1_r;
    logic [N_KEYS-1:0]     sync2_r;
    logic [N_KEYS-1:0]     samp_r;
    logic [N_KEYS-1:0]     pen_r;
    logic [N_KEYS-1:0]     pol_r;
    logic                  mode_r;
    logic                  ie_r;
    logic                  flag_r;
    logic                  flag_nxt;
    logic                  armed_r;
    logic                  armed_nxt;
    logic [KWIU_EVT_W-1:0] stat_r;
    logic [KWIU_EVT_W-1:0] stat_nxt;
    logic [KWIU_EVT_W-1:0] mask_r;
    logic [KWIU_EVT_W-1:0] evt_w;
    logic                  ready_r;
    logic [31:0]           rdata_r;
    logic                  err_r;
    logic                  irq_r;

    logic [N_KEYS-1:0]     asrt_w;
    logic [N_KEYS-1:0]     prev_asrt_w;
    logic [N_KEYS-1:0]     edge_w;
    logic                  any_asrt_w;
    logic                  edge_hit_w;
    logic                  lvl_hit_w;
    logic                  set_w;
    logic                  clr_w;
    logic                  acc_w;
    logic                  wr_w;
    logic                  ack_wr_w;
    logic                  hit_w;
    logic [31:0]           rd_mux_w;

    // Bus decode
    // Access completes one cycle after penable rises
    assign acc_w    = i_psel && i_penable && ready_r;
    assign wr_w     = acc_w && i_pwrite && hit_w;
    assign ack_wr_w = wr_w && (i_paddr == KWIU_OFS_CTRL) && i_pwdata[KWIU_BIT_ACK];

    always_comb begin
        hit_w = 1'b1;
        case (i_paddr)
            KWIU_OFS_CTRL: begin
                rd_mux_w = KWIU_RST_WORD;
                rd_mux_w[KWIU_BIT_MODE] = mode_r;
                rd_mux_w[KWIU_BIT_IE]   = ie_r;
                rd_mux_w[KWIU_BIT_FLAG] = flag_r;
            end
            KWIU_OFS_PEN: begin
                rd_mux_w = 32'(pen_r);
            end
            KWIU_OFS_POL: begin
                rd_mux_w = 32'(pol_r);
            end
            KWIU_OFS_STAT: begin
                rd_mux_w = 32'(stat_r);
            end
            KWIU_OFS_MASK: begin
                rd_mux_w = 32'(mask_r);
            end
            default: begin
                rd_mux_w = KWIU_RST_WORD;
                hit_w    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ready_r <= KWIU_RST_BIT;
            rdata_r <= KWIU_RST_WORD;
            err_r   <= KWIU_RST_BIT;
        end else begin
            ready_r <= i_psel && i_penable && !ready_r;
            if (i_psel && i_penable && !ready_r) begin
                rdata_r <= i_pwrite ? KWIU_RST_WORD : rd_mux_w;
                err_r   <= !hit_w;
            end
        end
    end

    // Configuration registers; acknowledge and flag bits are not stored here
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_r <= KWIU_RST_BIT;
            ie_r   <= KWIU_RST_BIT;
            pen_r  <= '0;
            pol_r  <= '0;
            mask_r <= KWIU_RST_EVT;
        end else if (wr_w) begin
            case (i_paddr)
                KWIU_OFS_CTRL: begin
                    mode_r <= i_pwdata[KWIU_BIT_MODE]; // see RULE13
                    ie_r   <= i_pwdata[KWIU_BIT_IE];
                end
                KWIU_OFS_PEN: begin
                    pen_r <= i_pwdata[N_KEYS-1:0]; // see RULE14
                end
                KWIU_OFS_POL: begin
                    pol_r <= i_pwdata[N_KEYS-1:0];
                end
                KWIU_OFS_MASK: begin
                    mask_r <= i_pwdata[KWIU_EVT_W-1:0];
                end
                default: begin
                    mode_r <= mode_r;
                end
            endcase
        end
    end

    // Two-stage synchroniser, then one stored sample for comparison
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            samp_r  <= '0;
        end else begin
            sync1_r <= i_keys;  // see RULE17
            sync2_r <= sync1_r; // see RULE17
            samp_r  <= sync2_r;
        end
    end

    // Asserted sense per input follows its polarity bit
    assign asrt_w      = pen_r & ~(sync2_r ^ pol_r); // see RULE12 see RULE16
    assign prev_asrt_w = ~(samp_r ^ pol_r);           // see RULE12
    assign edge_w      = asrt_w & ~prev_asrt_w;       // see RULE1 see RULE2
    assign any_asrt_w  = |asrt_w;

    assign edge_hit_w = armed_r && (|edge_w);  // see RULE4 see RULE5
    assign lvl_hit_w  = mode_r && any_asrt_w;  // see RULE6
    assign set_w      = edge_hit_w || lvl_hit_w;
    // Level mode refuses the clear while anything enabled is asserted
    assign clr_w = ack_wr_w && (!mode_r || !any_asrt_w); // see RULE8 see RULE9 see RULE10

    // Rearm only once all enabled inputs sit deasserted
    always_comb begin
        armed_nxt = armed_r;
        if (!any_asrt_w) begin
            armed_nxt = 1'b1; // see RULE4
        end else if (edge_hit_w) begin
            armed_nxt = 1'b0; // see RULE4
        end
    end

    // Set wins over a same-cycle acknowledge; bus writes other than the acknowledge never touch it
    always_comb begin
        flag_nxt = flag_r;
        if (set_w) begin
            flag_nxt = 1'b1;
        end else if (clr_w) begin
            flag_nxt = 1'b0; // see RULE15
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            armed_r <= KWIU_RST_BIT;
            flag_r  <= KWIU_RST_BIT;
        end else begin
            armed_r <= armed_nxt;
            flag_r  <= flag_nxt;
        end
    end

    // Event status: write one to clear, new events win
    always_comb begin
        evt_w = KWIU_RST_EVT;
        evt_w[KWIU_EVT_EDGE] = edge_hit_w;
        evt_w[KWIU_EVT_LVL]  = lvl_hit_w;
        evt_w[KWIU_EVT_HELD] = ack_wr_w && !clr_w;
        stat_nxt = stat_r;
        if (wr_w && (i_paddr == KWIU_OFS_STAT)) begin
            stat_nxt = stat_r & ~i_pwdata[KWIU_EVT_W-1:0];
        end
        stat_nxt = stat_nxt | evt_w;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_r <= KWIU_RST_EVT;
            irq_r  <= KWIU_RST_BIT;
        end else begin
            stat_r <= stat_nxt;
            irq_r  <= (flag_r && ie_r) || (|(stat_r & mask_r)); // see RULE7
        end
    end

    assign o_prdata  = rdata_r;
    assign o_pready  = ready_r;
    assign o_pslverr = err_r;
    assign o_irq     = irq_r;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_ack_edge;
        ack_wr_w && !mode_r;
    endsequence

    sequence s_ack_lvl_free;
        ack_wr_w && mode_r && !any_asrt_w;
    endsequence

    sequence s_quiet;
        !flag_r && !set_w;
    endsequence

    a_fall_edge_set: assert property ( // see RULE1
        armed_r && |(pen_r & ~pol_r & samp_r & ~sync2_r) |=> flag_r)
        else $error("falling edge did not set flag");
    a_rise_edge_set: assert property ( // see RULE2
        armed_r && |(pen_r & pol_r & ~samp_r & sync2_r) |=> flag_r)
        else $error("rising edge did not set flag");
    a_disarm_blocks: assert property ( // see RULE4
        !armed_r && !mode_r && !flag_r |=> !flag_r)
        else $error("edge seen while disarmed");
    a_level_sets_flag: assert property ( // see RULE6
        mode_r && any_asrt_w |=> flag_r)
        else $error("asserted level did not set flag");
    a_irq_follows: assert property ( // see RULE7
        flag_r && ie_r |=> o_irq)
        else $error("interrupt missing with flag enabled");
    a_ack_edge_clr: assert property ( // see RULE8
        s_ack_edge ##0 !set_w |=> !flag_r)
        else $error("edge mode acknowledge did not clear");
    a_ack_level_clr: assert property ( // see RULE9
        s_ack_lvl_free |=> !flag_r)
        else $error("level mode acknowledge did not clear");
    a_ack_held_keep: assert property ( // see RULE10
        ack_wr_w && mode_r && any_asrt_w |=> flag_r [*2])
        else $error("flag dropped while input asserted");
    a_flag_read_only: assert property ( // see RULE15
        s_quiet ##0 (wr_w && !ack_wr_w) |=> !flag_r)
        else $error("bus write changed flag");
    a_disabled_quiet: assert property ( // see RULE16
        pen_r == '0 && !flag_r |=> !flag_r)
        else $error("disabled input set flag");
    // Guarded by reset history so the reset-time pin value is never compared
    a_sync_two_stage: assert property ( // see RULE17
        $past(i_nrst, 2) |-> sync2_r == $past(i_keys, 2))
        else $error("synchroniser depth wrong");
    a_sync_first: assert property ( // see RULE17
        $past(i_nrst) |-> sync1_r == $past(i_keys))
        else $error("first sync stage wrong");
    a_no_irq_idle: assert property ( // see RULE7
        !(flag_r && ie_r) && ((stat_r & mask_r) == '0) |=> !o_irq)
        else $error("interrupt raised with nothing pending");
    a_ack_held_stat: assert property ( // see RULE10
        ack_wr_w && mode_r && any_asrt_w |=> stat_r[KWIU_EVT_HELD])
        else $error("refused acknowledge not recorded");
    a_rise_level: assert property ( // see RULE12
        mode_r && |(pen_r & pol_r & sync2_r) |=> flag_r)
        else $error("high level did not set flag");
    a_ready_pulse: assert property (
        o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_err_unmapped: assert property (
        i_psel && i_penable && !ready_r && !hit_w |=> o_pslverr)
        else $error("unmapped access without error");
    a_write_reads_zero: assert property (
        i_psel && i_penable && !ready_r && i_pwrite |=> o_prdata == '0)
        else $error("write returned nonzero read data");

endmodule

// ===== hdl/kwiu_pkg.sv
// Purpose: Constants shared by the key wake input unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package kwiu_pkg;
    localparam int unsigned KWIU_ADDR_W   = 8;
    localparam int unsigned KWIU_KEYS_DEF = 8;
    localparam int unsigned KWIU_EVT_W    = 3;

    localparam logic [7:0] KWIU_OFS_CTRL = 8'h00;
    localparam logic [7:0] KWIU_OFS_PEN  = 8'h04;
    localparam logic [7:0] KWIU_OFS_POL  = 8'h08;
    localparam logic [7:0] KWIU_OFS_STAT = 8'h0c;
    localparam logic [7:0] KWIU_OFS_MASK = 8'h10;

    // Control word field positions
    localparam int unsigned KWIU_BIT_MODE = 0;
    localparam int unsigned KWIU_BIT_IE   = 1;
    localparam int unsigned KWIU_BIT_ACK  = 2;
    localparam int unsigned KWIU_BIT_FLAG = 3;

    // Event status field positions
    localparam int unsigned KWIU_EVT_EDGE = 0;
    localparam int unsigned KWIU_EVT_LVL  = 1;
    localparam int unsigned KWIU_EVT_HELD = 2;

    localparam logic [31:0] KWIU_RST_WORD = 32'h0000_0000;
    localparam logic [2:0]  KWIU_RST_EVT  = 3'h0;
    localparam logic        KWIU_RST_BIT  = 1'b0;
endpackage

// ===== bench/kwiu_keys_model.sv
// Purpose: Key switch bank seen from the detector's pins
// Assumes: Press request is per key, polarity shared by all keys
// Notes:   Idle keys sit at the deasserted level of the chosen polarity
module kwiu_keys_model (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic [7:0] i_press,
    input  wire logic       i_pol,
    output logic      [7:0] o_keys
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_keys <= 8'hff;
        end else begin
            o_keys <= ~(i_press ^ {8{i_pol}});
        end
    end
endmodule

// ===== bench/key_pin_edge_level_detector_bench.sv
// Purpose: Self-checking bench for the key wake input unit
// Assumes: APB slave answers within a bounded number of cycles
// Notes:   Keys settle through two sync flops, so checks wait 8 cycles
module key_pin_edge_level_detector_bench;
    import kwiu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] MD = 32'h1, IE = 32'h2, AK = 32'h4, FL = 32'h8;
    logic        i_clk = 1'b0, i_nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pol = 1'b0;
    logic [7:0]  paddr = 8'h00, press = 8'h00, keys;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic        prdy, perr, irq, err;
    int          failures = 0, comparisons = 0, cyc = 0;
    always #2.5 i_clk = ~i_clk;
    kwiu_keys_model km (.i_clk(i_clk), .i_nrst(i_nrst), .i_press(press), .i_pol(pol), .o_keys(keys));
    kwiu_top #(.N_KEYS(8)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_keys(keys), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
        .o_pready(prdy), .o_pslverr(perr), .o_irq(irq));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        // Only the bench timeout ends a wait that never sees ready
        do begin
            @(posedge i_clk);
        end while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wt();
        repeat (8) @(posedge i_clk);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        rdc(KWIU_OFS_CTRL, 32'h0);
        rdc(KWIU_OFS_PEN, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(KWIU_OFS_CTRL, 32'h0);
        wr(KWIU_OFS_POL, 32'h0);
        wr(KWIU_OFS_PEN, 32'h1);
        wr(KWIU_OFS_CTRL, AK);
        wr(KWIU_OFS_CTRL, IE);
        press <= 8'h01;
        wt();
        chk({31'h0, irq}, 32'h1);
        rdc(KWIU_OFS_CTRL, IE | FL);
        wr(KWIU_OFS_CTRL, IE | AK);
        rdc(KWIU_OFS_CTRL, IE);
        wt();
        rdc(KWIU_OFS_CTRL, IE);
        wr(KWIU_OFS_CTRL, IE | FL);
        rdc(KWIU_OFS_CTRL, IE);
        press <= 8'h00;
        wt();
        rdc(KWIU_OFS_CTRL, IE);
        press <= 8'h01;
        wt();
        rdc(KWIU_OFS_CTRL, IE | FL);
        press <= 8'h00;
        wr(KWIU_OFS_CTRL, IE | AK);
        press <= 8'h02;
        wt();
        rdc(KWIU_OFS_CTRL, IE);
        wr(KWIU_OFS_PEN, 32'h80);
        press <= 8'h80;
        wt();
        rdc(KWIU_OFS_CTRL, IE | FL);
        press <= 8'h00;
        wr(KWIU_OFS_PEN, 32'h0);
        pol <= 1'b1;
        wr(KWIU_OFS_POL, 32'hff);
        wr(KWIU_OFS_PEN, 32'h1);
        wr(KWIU_OFS_CTRL, AK);
        press <= 8'h01;
        wt();
        rdc(KWIU_OFS_CTRL, FL);
        chk({31'h0, irq}, 32'h0);
        wr(KWIU_OFS_CTRL, MD);
        wr(KWIU_OFS_CTRL, MD | AK);
        rdc(KWIU_OFS_CTRL, MD | FL);
        rdc(KWIU_OFS_STAT, 32'h7);
        press <= 8'h02;
        wt();
        wr(KWIU_OFS_CTRL, MD | AK);
        rdc(KWIU_OFS_CTRL, MD);
        press <= 8'h00;
        wr(KWIU_OFS_CTRL, 32'h0);
        wr(KWIU_OFS_STAT, 32'h7);
        rdc(KWIU_OFS_STAT, 32'h0);
        wr(KWIU_OFS_MASK, 32'h1);
        press <= 8'h01;
        wt();
        chk({31'h0, irq}, 32'h1);
        rdc(KWIU_OFS_STAT, 32'h1);
        wr(KWIU_OFS_MASK, 32'h0);
        wt();
        chk({31'h0, irq}, 32'h0);
        wr(KWIU_OFS_MASK, 32'h1);
        wr(KWIU_OFS_STAT, 32'h1);
        wt();
        chk({31'h0, irq}, 32'h0);
        rdc(KWIU_OFS_STAT, 32'h0);
        end_of_test();
    end
endmodule
